// ### src/timer_pkg.sv
// Purpose: shared constants and types for the timer clock source block
// Assumes: 8-bit register port, one system clock
// Notes:   register offsets are word indices of the plain register port
package timer_pkg;

  ////////////////////////////////////////////////////////////////////////////
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int COUNT_W = 16;
  localparam int PHASE_W = 4;
  localparam int PRESC_W = 3;

  localparam logic [ADDR_W-1:0] ADDR_COUNT_LOW  = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_COUNT_HIGH = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_CTRL       = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_STATUS     = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_MASK       = 3'h4;

  // control register fields
  localparam int CTRL_RUN_BIT        = 0;
  localparam int CTRL_EXT_SRC_BIT    = 1;
  localparam int CTRL_SYNC_BYPASS_BIT = 2;
  localparam int CTRL_PRESC_LSB      = 3;
  localparam int CTRL_LP_OSC_BIT     = 5;
  localparam logic [DATA_W-1:0] CTRL_WR_MASK = 8'h3F;
  localparam logic [DATA_W-1:0] CTRL_RESET   = 8'h00;

  // status and mask fields
  localparam int STATUS_OVF_BIT = 0;
  localparam logic [DATA_W-1:0] STATUS_WR_MASK = 8'h01;
  localparam logic [DATA_W-1:0] STATUS_RESET   = 8'h00;
  localparam logic [DATA_W-1:0] MASK_RESET     = 8'h00;

  localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;
  localparam logic [COUNT_W-1:0] COUNT_MAX   = 16'hFFFF;
  localparam logic [DATA_W-1:0]  READ_ZERO   = 8'h00;

  // system clocks per instruction cycle
  localparam int INSTR_CLKS = 4;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {
    ARM_IDLE      = 2'b00,
    ARM_WAIT_FALL = 2'b01,
    ARM_READY     = 2'b11
  } arm_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic stable;
    logic rise;
    logic fall;
  } filter_state_t;

  typedef struct packed {
    logic [COUNT_W-1:0] count;
    logic [PRESC_W-1:0] presc;
    logic [PHASE_W-1:0] phase;
    logic [DATA_W-1:0]  ctrl;
    logic [DATA_W-1:0]  status;
    logic [DATA_W-1:0]  mask;
    logic [DATA_W-1:0]  rdata;
    logic               irq;
    logic               pend;
    arm_state_t         arm;
  } timer_state_t;

endpackage

// ### src/edge_filter.sv
// Purpose: pin input synchroniser with agreement filter and edge pulses
// Assumes: raw input is asynchronous to core_clk_in
// Notes:   edges are one-cycle pulses, delayed four clocks from the pin
`timescale 1ns/10ps
module edge_filter (
  input  wire logic core_clk_in,
  input  wire logic resetn_in,
  input  wire logic raw_in,
  output wire logic level_out,
  output wire logic rise_out,
  output wire logic fall_out
);

  ////////////////////////////////////////////////////////////////////////////
  timer_pkg::filter_state_t st_q;
  timer_pkg::filter_state_t st_d;

  always_comb begin
    st_d      = st_q;
    st_d.s1   = raw_in;
    // s1 feeds s2 only; metastability settles before anything decides
    st_d.s2   = st_q.s1;
    st_d.s3   = st_q.s2;
    st_d.rise = 1'b0;
    st_d.fall = 1'b0;
    if ((st_q.s2 == st_q.s3) && (st_q.s3 != st_q.stable)) begin
      st_d.stable = st_q.s3;
      st_d.rise   = st_q.s3;
      st_d.fall   = ~st_q.s3;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign level_out = st_q.stable;
  assign rise_out  = st_q.rise;
  assign fall_out  = st_q.fall;

endmodule

// ### src/timer_clock_source_prescaler.sv
// Purpose: clock source select, prescaler and 16-bit count for a timer
// Assumes: plain register port, read data one cycle after the read strobe
// Notes:   external inputs are filtered, so edges lag the pin by 4 clocks
//
// Notes on behaviour
// - internal source counts instruction cycles times prescale
// - external source works as timer or counter
// - count advances on external rising edges, prescaled
// - external clock resynchronised or not, by control bit
// - crystal oscillator usable when system on internal oscillator
// - falling edge must precede first counted rising edge
// - prescaler divides by one, two, four or eight
// - prescale counter hidden from software
// - writing either count byte clears the prescaler
// - bypass bit counts edges free of instruction phase
// - count is sixteen bits, read as two bytes
//
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/10ps
module timer_clock_source_prescaler #(
  parameter int CLKS_PER_INSTR = timer_pkg::INSTR_CLKS
) (
  input  wire logic                         core_clk_in,
  input  wire logic                         resetn_in,
  input  wire timer_pkg::reg_req_t          reg_req_in,
  input  wire logic                         ext_count_input_in,
  input  wire logic                         low_power_crystal_osc_in,
  input  wire logic                         internal_osc_mode_in,
  output wire logic [timer_pkg::DATA_W-1:0] rdata_out,
  output wire logic                         irq_out,
  output wire logic [timer_pkg::COUNT_W-1:0] count_out
);

  ////////////////////////////////////////////////////////////////////////////
  // elaboration check
  localparam int PHASE_MAX = (1 << timer_pkg::PHASE_W);

  generate
    if (CLKS_PER_INSTR < 1 || CLKS_PER_INSTR > PHASE_MAX) begin : g_chk
      $error("CLKS_PER_INSTR outside the range the phase counter holds");
    end
  endgenerate

  localparam logic [timer_pkg::PHASE_W-1:0] PHASE_LAST =
    timer_pkg::PHASE_W'(CLKS_PER_INSTR - 1);

  ////////////////////////////////////////////////////////////////////////////
  // prescaler mask: divide by 2**sel
  function automatic logic [timer_pkg::PRESC_W-1:0] presc_mask(
    input logic [1:0] sel
  );
    logic [timer_pkg::PRESC_W-1:0] m;
    m = 3'h0;
    case (sel)
      2'h0:    m = 3'h0;
      2'h1:    m = 3'h1;
      2'h2:    m = 3'h3;
      2'h3:    m = 3'h7;
      default: m = 3'h0;
    endcase
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // external inputs
  logic pin_rise;
  logic pin_fall;
  logic osc_rise;
  logic osc_fall;

  edge_filter u_pin_filter (
    .core_clk_in (core_clk_in),
    .resetn_in   (resetn_in),
    .raw_in      (ext_count_input_in),
    .level_out   (),
    .rise_out    (pin_rise),
    .fall_out    (pin_fall)
  );

  edge_filter u_osc_filter (
    .core_clk_in (core_clk_in),
    .resetn_in   (resetn_in),
    .raw_in      (low_power_crystal_osc_in),
    .level_out   (),
    .rise_out    (osc_rise),
    .fall_out    (osc_fall)
  );

  ////////////////////////////////////////////////////////////////////////////
  timer_pkg::timer_state_t st_q;
  timer_pkg::timer_state_t st_d;

  logic       run;
  logic       ext_src;
  logic       bypass;
  logic       use_osc;
  logic [1:0] presc_sel;
  logic       instr_tick;
  logic       src_rise;
  logic       src_fall;
  logic       src_tick;
  logic       count_tick;
  logic       wr_low;
  logic       wr_high;
  logic       ovf_set;
  logic [timer_pkg::DATA_W-1:0] ovf_bits;
  logic [timer_pkg::DATA_W-1:0] clr_bits;

  always_comb begin
    run       = st_q.ctrl[timer_pkg::CTRL_RUN_BIT];
    ext_src   = st_q.ctrl[timer_pkg::CTRL_EXT_SRC_BIT];
    bypass    = st_q.ctrl[timer_pkg::CTRL_SYNC_BYPASS_BIT];
    presc_sel = st_q.ctrl[timer_pkg::CTRL_PRESC_LSB +: 2];
    // crystal shares the system oscillator pins, so only when free
    use_osc   = st_q.ctrl[timer_pkg::CTRL_LP_OSC_BIT] &
                internal_osc_mode_in;
    instr_tick = (st_q.phase == PHASE_LAST);
    src_rise  = use_osc ? osc_rise : pin_rise;
    src_fall  = use_osc ? osc_fall : pin_fall;
    wr_low    = reg_req_in.wr &&
                (reg_req_in.addr == timer_pkg::ADDR_COUNT_LOW);
    wr_high   = reg_req_in.wr &&
                (reg_req_in.addr == timer_pkg::ADDR_COUNT_HIGH);
  end

  always_comb begin
    st_d       = st_q;
    src_tick   = 1'b0;
    count_tick = 1'b0;
    ovf_set    = 1'b0;
    ovf_bits   = timer_pkg::READ_ZERO;
    clr_bits   = timer_pkg::READ_ZERO;

    // instruction phase runs regardless of mode
    st_d.phase = instr_tick ? '0 : st_q.phase + 1'b1;

    // arming: a fresh start needs a falling edge first
    case (st_q.arm)
      timer_pkg::ARM_IDLE: begin
        if (run && ext_src) begin
          st_d.arm = timer_pkg::ARM_WAIT_FALL;
        end
      end
      timer_pkg::ARM_WAIT_FALL: begin
        if (src_fall) begin
          st_d.arm = timer_pkg::ARM_READY;
        end
      end
      timer_pkg::ARM_READY: begin
        st_d.arm = timer_pkg::ARM_READY;
      end
      default: begin
        st_d.arm = timer_pkg::ARM_IDLE;
      end
    endcase
    if (!run || !ext_src) begin
      st_d.arm = timer_pkg::ARM_IDLE;
    end

    // source tick before prescaling
    if (run) begin
      if (!ext_src) begin
        src_tick = instr_tick;
      end else if (st_q.arm == timer_pkg::ARM_READY) begin
        if (bypass) begin
          src_tick = src_rise;
        end else begin
          // resync: a seen edge waits for the instruction boundary
          if (src_rise) begin
            st_d.pend = 1'b1;
          end
          if (instr_tick && (st_q.pend || src_rise)) begin
            src_tick  = 1'b1;
            st_d.pend = 1'b0;
          end
        end
      end
    end
    if (!run || !ext_src || bypass) begin
      st_d.pend = 1'b0;
    end

    // prescaler, never visible on the register port
    if (src_tick) begin
      if ((st_q.presc & presc_mask(presc_sel)) ==
          presc_mask(presc_sel)) begin
        st_d.presc = '0;
        count_tick = 1'b1;
      end else begin
        st_d.presc = st_q.presc + 1'b1;
      end
    end

    if (count_tick) begin
      st_d.count = st_q.count + 1'b1;
      if (st_q.count == timer_pkg::COUNT_MAX) begin
        ovf_set = 1'b1;
      end
    end

    // software writes win over a concurrent increment
    if (wr_low) begin
      st_d.count[7:0] = reg_req_in.wdata;
      st_d.presc      = '0;
    end
    if (wr_high) begin
      st_d.count[15:8] = reg_req_in.wdata;
      st_d.presc       = '0;
    end
    if (reg_req_in.wr && (reg_req_in.addr == timer_pkg::ADDR_CTRL)) begin
      st_d.ctrl = reg_req_in.wdata & timer_pkg::CTRL_WR_MASK;
    end
    if (reg_req_in.wr && (reg_req_in.addr == timer_pkg::ADDR_MASK)) begin
      st_d.mask = reg_req_in.wdata & timer_pkg::STATUS_WR_MASK;
    end

    // write-one-to-clear, a same-cycle overflow keeps its flag
    if (reg_req_in.wr && (reg_req_in.addr == timer_pkg::ADDR_STATUS)) begin
      clr_bits = reg_req_in.wdata & timer_pkg::STATUS_WR_MASK;
    end
    ovf_bits[timer_pkg::STATUS_OVF_BIT] = ovf_set;
    st_d.status = (st_q.status & ~clr_bits) | ovf_bits;

    st_d.irq = |(st_d.status & st_d.mask);

    // read data stands one cycle only
    st_d.rdata = timer_pkg::READ_ZERO;
    if (reg_req_in.rd) begin
      case (reg_req_in.addr)
        timer_pkg::ADDR_COUNT_LOW:  st_d.rdata = st_q.count[7:0];
        timer_pkg::ADDR_COUNT_HIGH: st_d.rdata = st_q.count[15:8];
        timer_pkg::ADDR_CTRL:       st_d.rdata = st_q.ctrl;
        timer_pkg::ADDR_STATUS:     st_d.rdata = st_q.status;
        timer_pkg::ADDR_MASK:       st_d.rdata = st_q.mask;
        default:                    st_d.rdata = timer_pkg::READ_ZERO;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      st_q.count  <= timer_pkg::COUNT_RESET;
      st_q.presc  <= '0;
      st_q.phase  <= '0;
      st_q.ctrl   <= timer_pkg::CTRL_RESET;
      st_q.status <= timer_pkg::STATUS_RESET;
      st_q.mask   <= timer_pkg::MASK_RESET;
      st_q.rdata  <= timer_pkg::READ_ZERO;
      st_q.irq    <= 1'b0;
      st_q.pend   <= 1'b0;
      st_q.arm    <= timer_pkg::ARM_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  assign rdata_out = st_q.rdata;
  assign irq_out   = st_q.irq;
  assign count_out = st_q.count;

endmodule

// ### testbench/timer_src_props.sv
// Purpose: port checks for the timer clock source block
// Assumes: bound to the top module, ctrl and mask shadowed from writes
// Notes:   shadows mirror the bus, so they lag nothing the design sees
`timescale 1ns/10ps
module timer_src_props #(
  parameter int CLKS_PER_INSTR = 4
) (
  input wire logic                          core_clk_in,
  input wire logic                          resetn_in,
  input wire timer_pkg::reg_req_t           reg_req_in,
  input wire logic                          ext_count_input_in,
  input wire logic                          low_power_crystal_osc_in,
  input wire logic                          internal_osc_mode_in,
  input wire logic [timer_pkg::DATA_W-1:0]  rdata_out,
  input wire logic                          irq_out,
  input wire logic [timer_pkg::COUNT_W-1:0] count_out
);
  logic [7:0] ctrl_q;
  logic [7:0] mask_q;
  logic       cnt_wr;
  assign cnt_wr = reg_req_in.wr &&
                  reg_req_in.addr <= timer_pkg::ADDR_COUNT_HIGH;
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      ctrl_q <= 8'h00;
      mask_q <= 8'h00;
    end else if (reg_req_in.wr) begin
      if (reg_req_in.addr == timer_pkg::ADDR_CTRL)
        ctrl_q <= reg_req_in.wdata;
      if (reg_req_in.addr == timer_pkg::ADDR_MASK)
        mask_q <= reg_req_in.wdata;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);
  sequence lo_wr_s;
    reg_req_in.wr && reg_req_in.addr == timer_pkg::ADDR_COUNT_LOW;
  endsequence
  sequence hi_wr_s;
    reg_req_in.wr && reg_req_in.addr == timer_pkg::ADDR_COUNT_HIGH;
  endsequence
  sequence cnt_rd_s;
    reg_req_in.rd && reg_req_in.addr <= timer_pkg::ADDR_COUNT_HIGH;
  endsequence
  step_one_a: assert property ($changed(count_out) |->
    count_out == $past(count_out) + 16'h0001 || $past(cnt_wr))
    else $error("count moved by other than one");
  halt_hold_a: assert property (!ctrl_q[0] && !cnt_wr |=>
    $stable(count_out)) else $error("count moved while stopped");
  count_read_a: assert property (cnt_rd_s |=> rdata_out ==
    ($past(reg_req_in.addr[0]) ? $past(count_out[15:8])
                               : $past(count_out[7:0])))
    else $error("count byte read wrong");
  low_write_a: assert property (lo_wr_s |=>
    count_out[7:0] == $past(reg_req_in.wdata))
    else $error("low byte write lost");
  high_write_a: assert property (hi_wr_s |=>
    count_out[15:8] == $past(reg_req_in.wdata))
    else $error("high byte write lost");
  idle_read_a: assert property (!reg_req_in.rd |=>
    rdata_out == timer_pkg::READ_ZERO) else $error("read data not zero");
  unmapped_read_a: assert property (reg_req_in.rd &&
    reg_req_in.addr > timer_pkg::ADDR_MASK |=> rdata_out == 8'h00)
    else $error("unmapped read not zero");
  ctrl_read_a: assert property (reg_req_in.rd &&
    reg_req_in.addr == timer_pkg::ADDR_CTRL |=>
    rdata_out == ($past(ctrl_q) & timer_pkg::CTRL_WR_MASK))
    else $error("ctrl read wrong");
  irq_mask_a: assert property (irq_out |-> mask_q[0])
    else $error("irq while masked");
endmodule

bind timer_clock_source_prescaler timer_src_props #(
  .CLKS_PER_INSTR(CLKS_PER_INSTR)
) u_props (.core_clk_in, .resetn_in, .reg_req_in, .ext_count_input_in,
  .low_power_crystal_osc_in, .internal_osc_mode_in, .rdata_out,
  .irq_out, .count_out);

// ### testbench/ext_pulse_model.sv
// Purpose: pulse source for the count pin and the crystal input
// Assumes: half period of at least three clocks
// Notes:   starts low, so the first rise comes before any fall
`timescale 1ns/10ps
module ext_pulse_model #(
  parameter int HALF = 5
) (
  input  wire logic core_clk_in,
  input  wire logic run_in,
  input  wire logic xtal_in,
  output wire logic pin_out,
  output wire logic osc_out
);
  logic lvl_q;
  int   cnt_q;
  always_ff @(posedge core_clk_in) begin
    if (!run_in) begin
      lvl_q <= 1'b0;
      cnt_q <= 0;
    end else if (cnt_q == HALF - 1) begin
      cnt_q <= 0;
      lvl_q <= ~lvl_q;
    end else begin
      cnt_q <= cnt_q + 1;
    end
  end
  // the unused line sits low, as behind a pull-down
  assign pin_out = lvl_q & ~xtal_in;
  assign osc_out = lvl_q & xtal_in;
endmodule

// ### testbench/timer_clock_source_prescaler_tb_top.sv
// Purpose: self-checking bench for the timer clock source block
// Assumes: ctrl run 0, ext 1, bypass 2, prescale 4:3, crystal 5
// Notes:   internal windows are whole instruction cycles, so exact
`timescale 1ns/10ps
module timer_clock_source_prescaler_tb_top;
  localparam int         INSTR = 4;
  localparam int         HALF  = 5;
  localparam logic [7:0] EXT_CTRL [4] = '{8'h03, 8'h0F, 8'h23, 8'h23};
  localparam int         EXT_N    [4] = '{6, 7, 4, 4};
  localparam int         EXT_EXP  [4] = '{5, 3, 3, 0};
  localparam logic [3:0] EXT_OSC  = 4'b0100;
  localparam logic [3:0] EXT_XTAL = 4'b1100;
  logic                clk;
  logic                resetn;
  timer_pkg::reg_req_t req;
  logic                pin;
  logic                osc;
  logic                osc_mode;
  logic                gen_on;
  logic                gen_xtal;
  logic [7:0]          rdata;
  logic                irq;
  logic [15:0]         count;
  int                  err_total;
  int                  compares;
  timer_clock_source_prescaler #(.CLKS_PER_INSTR(INSTR)) uut (
    .core_clk_in(clk), .resetn_in(resetn), .reg_req_in(req),
    .ext_count_input_in(pin), .low_power_crystal_osc_in(osc),
    .internal_osc_mode_in(osc_mode), .rdata_out(rdata),
    .irq_out(irq), .count_out(count));
  ext_pulse_model #(.HALF(HALF)) u_src (.core_clk_in(clk),
    .run_in(gen_on), .xtal_in(gen_xtal), .pin_out(pin), .osc_out(osc));
  //////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge clk);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk);
    req.rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic rd_count(output logic [15:0] c);
    logic [7:0] lo;
    logic [7:0] hi;
    rd(timer_pkg::ADDR_COUNT_LOW, lo);
    rd(timer_pkg::ADDR_COUNT_HIGH, hi);
    c = {hi, lo};
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset_values();
    logic [7:0] d;
    wr(3'h5, 8'hFF);
    wr(timer_pkg::ADDR_CTRL, 8'hC0);
    for (int a = 0; a < 6; a++) begin
      rd(a[2:0], d);
      check({8'h00, d}, 16'h0000);
    end
  endtask
  task automatic t_internal();
    logic [15:0] c;
    for (int s = 0; s < 4; s++) begin
      // for s above 0, one lone tick leaves the prescaler part-way for the write to clear
      wr(timer_pkg::ADDR_CTRL, {3'h0, s[1:0], 3'h1});
      repeat (INSTR - 2) @(posedge clk);
      wr(timer_pkg::ADDR_CTRL, 8'h00);
      wr(timer_pkg::ADDR_COUNT_HIGH, 8'h00);
      wr(timer_pkg::ADDR_COUNT_LOW, 8'h00);
      wr(timer_pkg::ADDR_CTRL, {3'h0, s[1:0], 3'h1});
      repeat (3 * INSTR * (1 << s) - 2) @(posedge clk);
      wr(timer_pkg::ADDR_CTRL, 8'h00);
      rd_count(c);
      check(c, 16'h0003);
    end
  endtask
  task automatic t_overflow();
    logic [7:0] d;
    wr(timer_pkg::ADDR_MASK, 8'h01);
    wr(timer_pkg::ADDR_COUNT_HIGH, 8'hFF);
    wr(timer_pkg::ADDR_COUNT_LOW, 8'hFF);
    wr(timer_pkg::ADDR_CTRL, 8'h01);
    repeat (3 * INSTR) @(posedge clk);
    wr(timer_pkg::ADDR_CTRL, 8'h00);
    #1 check({15'h0000, irq}, 16'h0001);
    wr(timer_pkg::ADDR_MASK, 8'h00);
    @(posedge clk);
    #1 check({15'h0000, irq}, 16'h0000);
    rd(timer_pkg::ADDR_STATUS, d);
    check({8'h00, d}, 16'h0001);
    wr(timer_pkg::ADDR_MASK, 8'h01);
    wr(timer_pkg::ADDR_STATUS, 8'h01);
    @(posedge clk);
    #1 check({15'h0000, irq}, 16'h0000);
  endtask
  task automatic t_external();
    logic [15:0] c;
    for (int i = 0; i < 4; i++) begin
      wr(timer_pkg::ADDR_COUNT_HIGH, 8'h00);
      wr(timer_pkg::ADDR_COUNT_LOW, 8'h00);
      osc_mode <= EXT_OSC[i];
      gen_xtal <= EXT_XTAL[i];
      wr(timer_pkg::ADDR_CTRL, EXT_CTRL[i]);
      gen_on <= 1'b1;
      repeat (2 * HALF * EXT_N[i]) @(posedge clk);
      gen_on <= 1'b0;
      // filter and pending tick need a few clocks to drain
      repeat (20) @(posedge clk);
      wr(timer_pkg::ADDR_CTRL, 8'h00);
      rd_count(c);
      check(c, EXT_EXP[i][15:0]);
    end
  endtask
  task automatic summarize();
    if (err_total == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    resetn = 1'b0;
    req = '0;
    osc_mode = 1'b0;
    gen_on = 1'b0;
    gen_xtal = 1'b0;
    err_total = 0;
    compares = 0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    t_reset_values();
    t_internal();
    t_overflow();
    t_external();
    summarize();
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    summarize();
  end
endmodule
